// ===== prio_ctrl_defs.vh
// constants for the priority, mode and low-power control block
// assumes an 8-bit register port and a single 200 MHz system clock
`ifndef PRIO_CTRL_DEFS_VH
`define PRIO_CTRL_DEFS_VH

// register offsets
`define OFS_PRIO_MODE 8'h00
`define OFS_LP_CONFIG 8'h01
`define OFS_LP_STATUS 8'h02

// priority/mode register fields
`define BIT_BOOT_ROM 7
`define BIT_SPECIAL 6
`define BIT_MODE_A 5
`define BIT_READ_VIS 4
`define PSEL_MSB 3
`define PSEL_RESET 4'h5
`define PSEL_RESERVED 4'h5
`define SRC_EXT_IRQ 4'h6

// low-power config fields
`define BIT_RESTART_DLY 0
`define RESTART_DLY_RESET 1'b1

// restart delays, in clock cycles as specified
`define STOP_STAB_CYCLES 4064
`define STOP_SHORT_CYCLES 4

`endif

// ===== priority_mode_lowpower_ctrl.v
// priority select, mode latch and wait/stop control of an 8-bit controller
// assumes cpu core supplies mask bits and instruction strobes on the same clock
`timescale 1ns/1ps
`include "prio_ctrl_defs.vh"

module priority_mode_lowpower_ctrl #(
  parameter STAB_CYCLES = `STOP_STAB_CYCLES,
  parameter SHORT_CYCLES = `STOP_SHORT_CYCLES
) (
  input wire clock,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire mode_a_pin,
  input wire mode_b_pin,
  input wire pseudo_nmi_pin_n,
  input wire [15:0] source_req,
  input wire cpu_i_mask,
  input wire cpu_x_mask,
  input wire cpu_s_bit,
  input wire watchdog_off,
  input wire wait_instruction,
  input wire stop_instruction,
  output reg irq_valid,
  output reg [3:0] irq_source,
  output reg nmi_valid,
  output reg [1:0] op_mode,
  output reg boot_rom_mapped,
  output reg read_visible,
  output reg cpu_halt,
  output reg osc_enable,
  output reg timer_enable,
  output reg stack_req,
  output reg stop_nop,
  output reg resume_req,
  output reg nmi_service_req
);

  localparam ST_RUN = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_STOP = 2'b10;
  localparam ST_RECOVER = 2'b11;
  // 13 bits cover the long delay; a larger STAB_CYCLES needs a wider counter
  localparam [31:0] LONG_W32 = STAB_CYCLES;
  localparam [31:0] SHORT_W32 = SHORT_CYCLES;
  localparam [12:0] LONG_CNT = LONG_W32[12:0];
  localparam [12:0] SHORT_CNT = SHORT_W32[12:0];

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // fixed order, highest first: rank to source code
  function [3:0] order_src;
    input [3:0] rank;
    begin
      if (rank == 4'h0) begin
        order_src = `SRC_EXT_IRQ;
      end else if (rank == 4'h1) begin
        order_src = 4'h7;
      end else if (rank <= 4'h9) begin
        order_src = rank + 4'h6;
      end else begin
        order_src = rank - 4'hA;
      end
    end
  endfunction

  // promoted code, reserved folds onto external irq
  function [3:0] promoted;
    input [3:0] sel;
    begin
      promoted = (sel == `PSEL_RESERVED) ? `SRC_EXT_IRQ : sel;
    end
  endfunction

  // register select, shared by both write enables
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire [2:0] pin_raw = {pseudo_nmi_pin_n, mode_b_pin, mode_a_pin};
  wire [2:0] pin_sync;
  genvar g;

  // only the second stage feeds logic, so a metastable first stage stays contained
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      reg [1:0] stage_ff;
      always @(posedge clock) begin
        stage_ff <= {stage_ff[0], pin_raw[g]};
      end
      assign pin_sync[g] = stage_ff[1];
    end
  endgenerate

  wire mode_a_pin_sync = pin_sync[0];
  wire mode_b_pin_sync = pin_sync[1];
  wire nmi_active = ~pin_sync[2];

  //////////////////////////////////////////////////////////////////////////////
  // priority/mode register

  reg boot_rom_ff;
  reg special_ff;
  reg mode_a_ff;
  reg read_vis_ff;
  reg [3:0] psel_ff;
  reg restart_dly_ff;
  reg nxt_boot_rom;
  reg nxt_special;
  reg nxt_mode_a;
  reg nxt_read_vis;
  reg [3:0] nxt_psel;
  reg nxt_restart_dly;

  wire wr_prio = reg_wr & hit(reg_addr, `OFS_PRIO_MODE);
  wire wr_cfg = reg_wr & hit(reg_addr, `OFS_LP_CONFIG);

  always @* begin
    nxt_special = special_ff;
    nxt_mode_a = mode_a_ff;
    nxt_boot_rom = boot_rom_ff;
    nxt_read_vis = read_vis_ff;
    nxt_psel = psel_ff;
    nxt_restart_dly = restart_dly_ff;
    if (wr_prio) begin
      nxt_special = special_ff & reg_wdata[`BIT_SPECIAL];
      if (special_ff) begin
        nxt_mode_a = reg_wdata[`BIT_MODE_A];
        nxt_boot_rom = reg_wdata[`BIT_BOOT_ROM];
        nxt_read_vis = reg_wdata[`BIT_READ_VIS];
      end
      // a psel write with the i mask clear is dropped, not held back
      if (cpu_i_mask) begin
        nxt_psel = reg_wdata[`PSEL_MSB:0];
      end
    end
    // leaving special mode drops the special-only bits
    if (!nxt_special) begin
      nxt_boot_rom = 1'b0;
      nxt_read_vis = 1'b0;
    end
    if (wr_cfg) begin
      nxt_restart_dly = reg_wdata[`BIT_RESTART_DLY];
    end
  end

  // straps follow the pins while reset is low, so the last value is held at release
  always @(posedge clock) begin
    if (!rst_n) begin
      special_ff <= ~mode_b_pin_sync;
      mode_a_ff <= mode_a_pin_sync;
      boot_rom_ff <= ~mode_b_pin_sync & ~mode_a_pin_sync;
      read_vis_ff <= 1'b0;
      psel_ff <= `PSEL_RESET;
      restart_dly_ff <= `RESTART_DLY_RESET;
    end else begin
      special_ff <= nxt_special;
      mode_a_ff <= nxt_mode_a;
      boot_rom_ff <= nxt_boot_rom;
      read_vis_ff <= nxt_read_vis;
      psel_ff <= nxt_psel;
      restart_dly_ff <= nxt_restart_dly;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // priority resolution

  reg [3:0] nxt_src;
  reg nxt_any;
  reg [3:0] cand;
  integer k;

  always @* begin
    cand = 4'h0;
    nxt_src = 4'h0;
    nxt_any = 1'b0;
    // reserved slot never requests on its own
    for (k = 14; k >= 0; k = k - 1) begin
      cand = order_src(k[3:0]);
      if (source_req[cand]) begin
        nxt_src = cand;
        nxt_any = 1'b1;
      end
    end
    if (source_req[promoted(psel_ff)]) begin
      nxt_src = promoted(psel_ff);
      nxt_any = 1'b1;
    end
  end

  // source code doubles as vector index, so promotion never moves the vector
  always @(posedge clock) begin
    if (!rst_n) begin
      irq_valid <= 1'b0;
      irq_source <= 4'h0;
      nmi_valid <= 1'b0;
    end else begin
      irq_valid <= nxt_any & ~cpu_i_mask;
      irq_source <= nxt_src;
      nmi_valid <= nmi_active & ~cpu_x_mask;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wait / stop sequencing

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [12:0] cnt_ff;
  reg [12:0] nxt_cnt;
  reg nmi_wake_ff;
  reg nxt_nmi_wake;
  reg timer_off_ff;
  reg nxt_timer_off;
  reg nxt_stack;
  reg nxt_stop_nop;
  reg nxt_resume;
  reg nxt_nmi_service;

  // an unmasked winning source or nmi ends wait; only the external irq or the nmi ends stop
  wire unmasked_irq = nxt_any & ~cpu_i_mask;
  wire unmasked_nmi = nmi_active & ~cpu_x_mask;
  wire ext_irq_wake = source_req[`SRC_EXT_IRQ] & ~cpu_i_mask;
  wire wait_wake = unmasked_irq | unmasked_nmi;
  wire stop_wake = nmi_active | ext_irq_wake;
  // x is looked at when the delay ends, not at the wake itself
  wire nmi_serviced = nmi_wake_ff & ~cpu_x_mask;

  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_nmi_wake = nmi_wake_ff;
    nxt_timer_off = timer_off_ff;
    nxt_stack = 1'b0;
    nxt_stop_nop = 1'b0;
    nxt_resume = 1'b0;
    nxt_nmi_service = 1'b0;
    case (state_ff)
      ST_RUN: begin
        if (wait_instruction) begin
          nxt_state = ST_WAIT;
          nxt_stack = 1'b1;
          nxt_timer_off = cpu_i_mask & watchdog_off;
        end else if (stop_instruction) begin
          if (cpu_s_bit) begin
            nxt_stop_nop = 1'b1;
          end else begin
            nxt_state = ST_STOP;
          end
        end
      end
      ST_WAIT: begin
        if (wait_wake) begin
          nxt_state = ST_RUN;
          nxt_timer_off = 1'b0;
          nxt_resume = 1'b1;
        end
      end
      ST_STOP: begin
        // nmi wakes regardless of x; the x bit only picks the path
        if (stop_wake) begin
          nxt_state = ST_RECOVER;
          nxt_nmi_wake = nmi_active;
          nxt_cnt = restart_dly_ff ? LONG_CNT : SHORT_CNT;
        end
      end
      ST_RECOVER: begin
        if (cnt_ff <= 13'h0001) begin
          nxt_state = ST_RUN;
          nxt_cnt = 13'h0000;
          nxt_nmi_service = nmi_serviced;
          nxt_resume = ~nmi_serviced;
          nxt_nmi_wake = 1'b0;
        end else begin
          nxt_cnt = cnt_ff - 13'h0001;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= ST_RUN;
      cnt_ff <= 13'h0000;
      nmi_wake_ff <= 1'b0;
      timer_off_ff <= 1'b0;
      stack_req <= 1'b0;
      stop_nop <= 1'b0;
      resume_req <= 1'b0;
      nmi_service_req <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      nmi_wake_ff <= nxt_nmi_wake;
      timer_off_ff <= nxt_timer_off;
      stack_req <= nxt_stack;
      stop_nop <= nxt_stop_nop;
      resume_req <= nxt_resume;
      nmi_service_req <= nxt_nmi_service;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs and register reads

  // status packs the sequencer state beside the nmi wake and timer-off flags
  wire [7:0] prio_word = {boot_rom_ff, special_ff, mode_a_ff, read_vis_ff, psel_ff};
  wire [7:0] cfg_word = {7'h00, restart_dly_ff};
  wire [7:0] status_word = {3'h0, timer_off_ff, nmi_wake_ff, 1'b0, state_ff};

  always @(posedge clock) begin
    if (!rst_n) begin
      op_mode <= 2'b00;
      boot_rom_mapped <= 1'b0;
      read_visible <= 1'b0;
      cpu_halt <= 1'b0;
      osc_enable <= 1'b1;
      timer_enable <= 1'b1;
      reg_rdata <= 8'h00;
    end else begin
      op_mode <= {special_ff, mode_a_ff};
      boot_rom_mapped <= boot_rom_ff;
      read_visible <= read_vis_ff;
      // halt trails the state by one edge
      cpu_halt <= (state_ff != ST_RUN);
      osc_enable <= (state_ff != ST_STOP);
      timer_enable <= ~timer_off_ff & (state_ff != ST_STOP);
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `OFS_PRIO_MODE: reg_rdata <= prio_word;
          `OFS_LP_CONFIG: reg_rdata <= cfg_word;
          `OFS_LP_STATUS: reg_rdata <= status_word;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// ===== prio_checker.sv
// checker: port relations of the priority and low-power block
// assumes bind into the block; one clock, synchronous reset
`timescale 1ns/1ps
module prio_checker (
  input logic clock,
  input logic rst_n,
  input logic [15:0] source_req,
  input logic cpu_i_mask,
  input logic cpu_s_bit,
  input logic watchdog_off,
  input logic wait_instruction,
  input logic stop_instruction,
  input logic irq_valid,
  input logic [1:0] op_mode,
  input logic boot_rom_mapped,
  input logic read_visible,
  input logic cpu_halt,
  input logic osc_enable,
  input logic timer_enable,
  input logic stack_req,
  input logic stop_nop
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
////////////////
  property p_boot; !op_mode[1] |-> !boot_rom_mapped; endproperty
  a_boot: assert property (p_boot) else $error("boot rom outside special");
  property p_vis; !op_mode[1] |-> !read_visible; endproperty
  a_vis: assert property (p_vis) else $error("visibility outside special");
  property p_wait; wait_instruction && !cpu_halt |=> stack_req ##1 cpu_halt; endproperty
  a_wait: assert property (p_wait) else $error("wait did not stack");
  property p_tmr;
    wait_instruction && !cpu_halt && cpu_i_mask && watchdog_off |-> ##[1:2] !timer_enable;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer left on in wait");
  property p_nop; stop_instruction && cpu_s_bit && !cpu_halt |=> stop_nop && !cpu_halt; endproperty
  a_nop: assert property (p_nop) else $error("disabled stop halted");
  property p_stop;
    stop_instruction && !cpu_s_bit && !cpu_halt |-> ##[1:2] (!osc_enable && cpu_halt);
  endproperty
  a_stop: assert property (p_stop) else $error("stop kept oscillator");
  property p_mask; cpu_i_mask |=> !irq_valid; endproperty
  a_mask: assert property (p_mask) else $error("irq through mask");
  property p_irq; !cpu_i_mask && (source_req & 16'hFFDF) != 16'h0000 |=> irq_valid; endproperty
  a_irq: assert property (p_irq) else $error("unmasked irq lost");
endmodule

// ===== cpu_core_model.sv
// stand-in for the cpu core and the on-chip interrupt sources
// assumes the bench moves the want_ knobs just after rising edges
`timescale 1ns/1ps
module cpu_core_model (
  input logic cpu_halt,
  input logic wi,
  input logic wx,
  input logic ws,
  input logic wd,
  input logic ww,
  input logic wst,
  input logic [15:0] wreq,
  output logic cpu_i_mask,
  output logic cpu_x_mask,
  output logic cpu_s_bit,
  output logic watchdog_off,
  output logic wait_instruction,
  output logic stop_instruction,
  output logic [15:0] source_req
);
  assign cpu_i_mask = wi;
  assign cpu_x_mask = wx;
  assign cpu_s_bit = ws;
  assign watchdog_off = wd;
  // a halted core fetches nothing
  assign wait_instruction = ww & ~cpu_halt;
  assign stop_instruction = wst & ~cpu_halt;
  // code 5 names no source
  assign source_req = wreq & 16'hFFDF;
endmodule

// ===== priority_mode_lowpower_ctrl_bench.sv
// bench: register, priority and low-power scenarios
// assumes the block, its defs header, the core model and the checker
`timescale 1ns/1ps
`include "prio_ctrl_defs.vh"
module priority_mode_lowpower_ctrl_bench;
  localparam int STAB = 8;
  logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, mode_a_pin = 0, mode_b_pin = 0;
  logic pseudo_nmi_pin_n = 1, wi = 1, wx = 1, ws = 0, wd = 1, ww = 0, wst = 0, rd_d1 = 0, svc;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [15:0] wreq = 16'h0000, source_req, rv, req;
  logic irq_valid, nmi_valid, boot_rom_mapped, read_visible, cpu_halt, osc_enable, timer_enable;
  logic stack_req, stop_nop, resume_req, nmi_service_req, cpu_i_mask, cpu_x_mask, cpu_s_bit;
  logic watchdog_off, wait_instruction, stop_instruction;
  logic [3:0] irq_source;
  logic [1:0] op_mode;
  logic [7:0] exp_q[$];
  int miscompares = 0, comparisons = 0, n1, n2, k, c, seed = 32'hc8af;
  priority_mode_lowpower_ctrl #(.STAB_CYCLES(STAB)) u_priority_mode_lowpower_ctrl (.*);
  cpu_core_model u_cpu_core_model (.*);
  initial forever #2.5 clock = ~clock;
////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  task automatic op(input logic s);
    @(posedge clock);
    ww <= !s;
    wst <= s;
    @(posedge clock);
    ww <= 1'b0;
    wst <= 1'b0;
  endtask
  // bounded wait for the wake pulse
  task automatic wake(output int n);
    n = 0;
    while (resume_req !== 1'b1 && nmi_service_req !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    svc = nmi_service_req;
    if (n == 100) miscompares++;
  endtask
  task automatic reset_to(input logic b, input logic a);
    @(posedge clock);
    rst_n <= 1'b0;
    mode_b_pin <= b;
    mode_a_pin <= a;
    // three edges so the straps clear the synchroniser
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
  endtask
  function automatic logic [3:0] win(input logic [15:0] r, input logic [3:0] p);
    int i;
    win = 4'h0;
    for (i = 14; i >= 0; i--) begin
      if (r[(i < 10) ? i + 6 : i - 10]) win = 4'((i < 10) ? i + 6 : i - 10);
    end
    if (p == `PSEL_RESERVED) p = `SRC_EXT_IRQ;
    if (r[p]) win = p;
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
////////////////
  always @(posedge clock) begin
    if (rd_d1) check(reg_rdata, exp_q.pop_front(), "reg_rdata");
    rd_d1 <= reg_rd;
  end
  initial begin
    #200000;
    miscompares++;
    wrap_up;
  end
  initial begin
    reset_to(1'b0, 1'b0);
    rd(`OFS_PRIO_MODE, 8'hC5);
    rd(`OFS_LP_CONFIG, 8'h01);
    rd(8'h07, 8'h00);
    check({7'h0, boot_rom_mapped}, 8'h01, "boot_rom_mapped");
    check({6'h0, op_mode}, 8'h02, "op_mode");
    wr(`OFS_PRIO_MODE, 8'hF3);
    rd(`OFS_PRIO_MODE, 8'hF3);
    check({7'h0, read_visible}, 8'h01, "read_visible");
    wi <= 1'b0;
    wr(`OFS_PRIO_MODE, 8'hE7);
    rd(`OFS_PRIO_MODE, 8'hE3);
    wi <= 1'b1;
    wr(`OFS_PRIO_MODE, 8'h20);
    wr(`OFS_PRIO_MODE, 8'hFF);
    rd(`OFS_PRIO_MODE, 8'h2F);
    check({6'h0, op_mode}, 8'h01, "op_mode");
    for (c = 0; c < 16; c++) begin
      wi <= 1'b1;
      wr(`OFS_PRIO_MODE, 8'(c));
      wi <= 1'b0;
      for (k = 0; k < 4; k++) begin
        rv = (k == 0) ? 16'hFFFF : 16'($random(seed));
        wreq <= rv;
        repeat (2) @(posedge clock);
        req = rv & 16'hFFDF;
        check({7'h0, irq_valid}, {7'h0, |req}, "irq_valid");
        if (|req) check({4'h0, irq_source}, {4'h0, win(req, 4'(c))}, "irq_source");
      end
    end
    wi <= 1'b1;
    wreq <= 16'h0000;
    op(1'b0);
    rd(`OFS_LP_STATUS, 8'h11);
    check({7'h0, timer_enable}, 8'h00, "timer_enable");
    check({7'h0, cpu_halt}, 8'h01, "cpu_halt");
    wi <= 1'b0;
    wreq <= 16'h0001;
    wake(n1);
    check({7'h0, svc}, 8'h00, "svc");
    wi <= 1'b1;
    wreq <= 16'h0000;
    wd <= 1'b0;
    op(1'b0);
    rd(`OFS_LP_STATUS, 8'h01);
    check({7'h0, timer_enable}, 8'h01, "timer_enable");
    wi <= 1'b0;
    wreq <= 16'h0001;
    wake(n1);
    wd <= 1'b1;
    check({7'h0, svc}, 8'h00, "svc");
    wi <= 1'b1;
    wreq <= 16'h0000;
    ws <= 1'b1;
    op(1'b1);
    rd(`OFS_LP_STATUS, 8'h00);
    ws <= 1'b0;
    op(1'b1);
    rd(`OFS_LP_STATUS, 8'h02);
    pseudo_nmi_pin_n <= 1'b0;
    wake(n1);
    pseudo_nmi_pin_n <= 1'b1;
    check({7'h0, svc}, 8'h00, "svc");
    check({7'h0, nmi_valid}, 8'h00, "nmi_valid");
    wr(`OFS_LP_CONFIG, 8'h00);
    wx <= 1'b0;
    op(1'b1);
    pseudo_nmi_pin_n <= 1'b0;
    wake(n2);
    pseudo_nmi_pin_n <= 1'b1;
    wx <= 1'b1;
    check({7'h0, svc}, 8'h01, "svc");
    check({7'h0, nmi_valid}, 8'h01, "nmi_valid");
    check(8'(n1 - n2), 8'(STAB - `STOP_SHORT_CYCLES), "delay");
    op(1'b1);
    wi <= 1'b0;
    wreq <= 16'h0040;
    wake(n1);
    check({7'h0, svc}, 8'h00, "svc");
    wreq <= 16'h0001;
    op(1'b1);
    repeat (20) @(posedge clock);
    rd(`OFS_LP_STATUS, 8'h02);
    reset_to(1'b1, 1'b1);
    rd(`OFS_LP_STATUS, 8'h00);
    rd(`OFS_PRIO_MODE, 8'h25);
    check({7'h0, osc_enable}, 8'h01, "osc_enable");
    repeat (3) @(posedge clock);
    wrap_up;
  end
endmodule
bind priority_mode_lowpower_ctrl prio_checker u_prio_checker (.*);
